// ### common/bch_defs.svh
`ifndef BCH_DEFS_SVH
`define BCH_DEFS_SVH

// ==========================================================================
// timing
// ==========================================================================
`define BCH_CLK_MHZ        125
`define BCH_CLK_NS         8
// power-on clear: 8 periods of the 400 kHz device oscillator
`define BCH_POR_NS         20000
`define BCH_POR_CYC        ((`BCH_POR_NS + `BCH_CLK_NS - 1) / `BCH_CLK_NS)
// stretched digit strobe width
`define BCH_STRETCH_US     60
`define BCH_STRETCH_CYC    (`BCH_STRETCH_US * `BCH_CLK_MHZ)
`define BCH_CNT_W          13
`define BCH_RDY_PULSES     2'h2

// ==========================================================================
// register offsets (byte addresses)
// ==========================================================================
`define BCH_ADR_CMD        8'h00
`define BCH_ADR_CFG        8'h04
`define BCH_ADR_STAT       8'h08
`define BCH_ADR_DIG_BASE   8'h40
`define BCH_ADR_DIG_LAST   8'h6c

// ==========================================================================
// field positions and reset values
// ==========================================================================
`define BCH_CMD_SEND       8
`define BCH_CMD_INIT       9
`define BCH_CMD_RECV       10
`define BCH_STAT_BUSY      0
`define BCH_STAT_READY     1
`define BCH_STAT_DONE      2
`define BCH_STAT_DEV_ERR   3
`define BCH_STAT_SIGN      4
`define BCH_STAT_FMT_ERR   5
`define BCH_MDC_RST        4'h8
`define BCH_MDC_MAX        4'h8

// ==========================================================================
// floating point digit layout
// ==========================================================================
`define BCH_DIG_N          12
`define BCH_POS_SIGN       4'h2
`define BCH_POS_POINT      4'h3
`define BCH_POS_LSD_OFS    4'h3
`define BCH_POINT_MSD      4'hb
`define BCH_POINT_TOP      4'hc

`endif

// ### common/bch_pkg.sv
package bch_pkg;

    // ======================================================================
    // controller states, one-hot
    // ======================================================================
    typedef enum logic [8:0] {
        ST_IDLE      = 9'h001,
        ST_POR       = 9'h002,
        ST_SKIP      = 9'h004,
        ST_SEND_WAIT = 9'h008,
        ST_SEND_LOW  = 9'h010,
        ST_RECV_LOW  = 9'h020,
        ST_RECV_HIGH = 9'h040,
        ST_RECV_GATE = 9'h080,
        ST_RECV_TAKE = 9'h100
    } bch_state_e;

    typedef logic [3:0] bch_digit_t;

endpackage : bch_pkg

// ### common/bch_sync_if.sv
`timescale 1ns/100ps

// ==========================================================================
// raw levels in, synchronised out
// ==========================================================================
interface bch_sync_if #(
    parameter int W = 3
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;

    modport sink   (input raw, output sync);
    modport source (output raw, input sync);
endinterface : bch_sync_if

// ### design/bch_host.sv
`timescale 1ns/100ps
`include "bch_defs.svh"

module bch_host #(
    parameter int STRETCH_CYC = `BCH_STRETCH_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // device inputs side
    output logic      [5:0]  instr_in_lines_o,
    output logic             hold_o,
    output logic             por_o,
    // device outputs side
    input  wire logic        rdy_i,
    input  wire logic        digit_strobe_n_i,
    input  wire logic        instr_phase_select_i,
    input  wire logic        err_i,
    input  wire logic [3:0]  dig_out_i,
    // digit buffer gates
    output logic             buf_gate_a_o,
    output logic             buf_gate_b_o
);

    // ======================================================================
    // synchronisers
    // ======================================================================
    bch_sync_if #(.W(3)) sif ();

    assign sif.raw = {rdy_i, digit_strobe_n_i, instr_phase_select_i};

    bch_sync #(.W(3)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .sig   (sif.sink)
    );

    logic rdy_s;
    logic das_s;
    logic instr_phase_select_s;
    assign rdy_s  = sif.sync[2];
    assign das_s  = sif.sync[1];
    assign instr_phase_select_s = sif.sync[0];

    // ======================================================================
    // edges and strobe stretcher
    // ======================================================================
    logic                  rdy_d;
    logic                  das_d;
    logic                  instr_phase_select_d;
    logic [`BCH_CNT_W-1:0] str_cnt;
    logic                  next_rdy_d;
    logic                  next_das_d;
    logic                  next_instr_phase_select_d;
    logic [`BCH_CNT_W-1:0] next_str_cnt;
    logic                  rdy_fall;
    logic                  instr_phase_select_rise;
    logic                  das_wide_n;

    assign rdy_fall  = rdy_d & ~rdy_s;
    assign instr_phase_select_rise = ~instr_phase_select_d & instr_phase_select_s;
    // 10 us pulse held low 60 us, inside 140 us
    assign das_wide_n = das_s & (str_cnt == '0);

    always_comb begin
        next_rdy_d   = rdy_s;
        next_das_d   = das_s;
        next_instr_phase_select_d  = instr_phase_select_s;
        next_str_cnt = str_cnt;
        if (das_d & ~das_s) begin
            next_str_cnt = STRETCH_CYC[`BCH_CNT_W-1:0];
        end else if (str_cnt != '0) begin
            next_str_cnt = str_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdy_d   <= 1'b0;
            das_d   <= 1'b1;
            instr_phase_select_d  <= 1'b1;
            str_cnt <= '0;
        end else begin
            rdy_d   <= next_rdy_d;
            das_d   <= next_das_d;
            instr_phase_select_d  <= next_instr_phase_select_d;
            str_cnt <= next_str_cnt;
        end
    end

    // ======================================================================
    // control state machine and registers
    // ======================================================================
    bch_pkg::bch_state_e   state;
    bch_pkg::bch_state_e   next_state;
    logic [`BCH_CNT_W-1:0] tmr;
    logic [`BCH_CNT_W-1:0] next_tmr;
    logic [1:0]            pulses;
    logic [1:0]            next_pulses;
    logic [3:0]            pos;
    logic [3:0]            next_pos;
    logic [3:0]            mdc;
    logic [3:0]            next_mdc;
    logic [5:0]            word;
    logic [5:0]            next_word;
    logic                  recv_after;
    logic                  next_recv_after;
    logic                  ready;
    logic                  next_ready;
    logic                  done;
    logic                  next_done;
    logic                  hold;
    logic                  next_hold;
    logic                  por;
    logic                  next_por;
    logic                  gate;
    logic                  next_gate;
    bch_pkg::bch_digit_t   digs [`BCH_DIG_N];
    logic                  dig_we;
    logic                  wr;
    logic                  rd_acc;
    logic                  busy;

    assign busy   = (state != bch_pkg::ST_IDLE);
    assign wr     = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign rd_acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign dig_we = (state == bch_pkg::ST_RECV_TAKE);

    // next state and commands; commands while busy are ignored
    always_comb begin
        next_state      = state;
        next_tmr        = tmr;
        next_pulses     = pulses;
        next_pos        = pos;
        next_mdc        = mdc;
        next_word       = word;
        next_recv_after = recv_after;
        next_ready      = ready;
        next_done       = done;
        next_hold       = hold;
        next_por        = 1'b0;
        next_gate       = 1'b0;
        // a done set below wins over this clear
        if (wr && wb_adr_i == `BCH_ADR_STAT && wb_sel_i[0] && wb_dat_i[`BCH_STAT_DONE]) begin
            next_done = 1'b0;
        end
        if (wr && wb_adr_i == `BCH_ADR_CFG && wb_sel_i[0] && !busy) begin
            if (wb_dat_i[3:0] != 4'h0 && wb_dat_i[3:0] <= `BCH_MDC_MAX) begin
                next_mdc = wb_dat_i[3:0];
            end
        end
        case (state)
            bch_pkg::ST_IDLE: begin
                if (wr && wb_adr_i == `BCH_ADR_CMD && wb_sel_i[1]) begin
                    if (wb_dat_i[`BCH_CMD_INIT]) begin
                        next_state  = bch_pkg::ST_POR;
                        next_tmr    = `BCH_CNT_W'(`BCH_POR_CYC);
                        next_por    = 1'b1;
                        next_hold   = 1'b0;
                        next_ready  = 1'b0;
                        next_pulses = 2'h0;
                    end else if (wb_dat_i[`BCH_CMD_SEND] && ready && wb_sel_i[0]) begin
                        // latch loads from the store data
                        next_word       = wb_dat_i[5:0];
                        next_recv_after = wb_dat_i[`BCH_CMD_RECV];
                        next_state      = bch_pkg::ST_SEND_WAIT;
                    end
                end
            end
            bch_pkg::ST_POR: begin
                // clear held 8 device clocks
                next_por = 1'b1;
                next_tmr = tmr - 1'b1;
                if (tmr == `BCH_CNT_W'(1)) begin
                    next_por   = 1'b0;
                    next_state = bch_pkg::ST_SKIP;
                end
            end
            bch_pkg::ST_SKIP: begin
                // two ready pulses after init
                if (rdy_fall) begin
                    next_pulses = pulses + 2'h1;
                    if (pulses + 2'h1 == `BCH_RDY_PULSES) begin
                        next_hold  = 1'b1;
                        next_ready = 1'b1;
                        next_state = bch_pkg::ST_IDLE;
                    end
                end
            end
            bch_pkg::ST_SEND_WAIT: begin
                // device waits while wait-request high
                if (rdy_s) begin
                    next_hold  = 1'b0;
                    next_state = bch_pkg::ST_SEND_LOW;
                end
            end
            bch_pkg::ST_SEND_LOW: begin
                // ready low: latch sampled
                if (!rdy_s) begin
                    next_hold = 1'b1;
                    next_pos  = `BCH_POS_SIGN;
                    if (recv_after) begin
                        next_state = bch_pkg::ST_RECV_LOW;
                    end else begin
                        next_done  = 1'b1;
                        next_state = bch_pkg::ST_IDLE;
                    end
                end
            end
            bch_pkg::ST_RECV_LOW: begin
                if (!das_wide_n) begin
                    next_state = bch_pkg::ST_RECV_HIGH;
                end else if (instr_phase_select_rise) begin
                    next_done  = 1'b1;
                    next_state = bch_pkg::ST_IDLE;
                end
            end
            bch_pkg::ST_RECV_HIGH: begin
                if (das_wide_n) begin
                    next_gate  = 1'b1;
                    next_state = bch_pkg::ST_RECV_GATE;
                end
            end
            bch_pkg::ST_RECV_GATE: begin
                next_state = bch_pkg::ST_RECV_TAKE;
            end
            bch_pkg::ST_RECV_TAKE: begin
                // advance; stop after last mantissa digit
                next_pos = pos + 4'h1;
                if (pos == mdc + `BCH_POS_LSD_OFS) begin
                    next_done  = 1'b1;
                    next_state = bch_pkg::ST_IDLE;
                end else begin
                    next_state = bch_pkg::ST_RECV_LOW;
                end
            end
            default: begin
                next_state = bch_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state      <= bch_pkg::ST_IDLE;
            tmr        <= '0;
            pulses     <= 2'h0;
            pos        <= `BCH_POS_SIGN;
            mdc        <= `BCH_MDC_RST;
            word       <= 6'h00;
            recv_after <= 1'b0;
            ready      <= 1'b0;
            done       <= 1'b0;
            hold       <= 1'b0;
            por        <= 1'b0;
            gate       <= 1'b0;
        end else begin
            state      <= next_state;
            tmr        <= next_tmr;
            pulses     <= next_pulses;
            pos        <= next_pos;
            mdc        <= next_mdc;
            word       <= next_word;
            recv_after <= next_recv_after;
            ready      <= next_ready;
            done       <= next_done;
            hold       <= next_hold;
            por        <= next_por;
            gate       <= next_gate;
        end
    end

    // digit store, unreset so it maps to memory
    always_ff @(posedge clk_i) begin
        if (dig_we) begin
            digs[pos] <= dig_out_i;
        end
    end

    // ======================================================================
    // floating point view of captured number
    // ======================================================================
    logic       sign_neg;
    logic [3:0] point;
    logic [3:0] point_lsd;
    logic [3:0] int_digits;
    logic       fmt_err;

    assign sign_neg   = digs[`BCH_POS_SIGN][0];
    assign point      = digs[`BCH_POS_POINT];
    // msd is point value 11: integer digits = 12 - point
    assign int_digits = `BCH_POINT_TOP - point;
    assign point_lsd  = `BCH_POINT_TOP - mdc;
    assign fmt_err    = (point > `BCH_POINT_MSD) || (point < point_lsd);

    // ======================================================================
    // wishbone read mux and acknowledge
    // ======================================================================
    logic [31:0] rd_val;
    logic [31:0] next_dat;
    logic        next_ack;
    logic [3:0]  rd_idx;

    assign rd_idx = 4'((wb_adr_i - `BCH_ADR_DIG_BASE) >> 2);

    always_comb begin
        rd_val = 32'h0000_0000;
        if (wb_adr_i == `BCH_ADR_CMD) begin
            rd_val = {26'h000_0000, word};
        end else if (wb_adr_i == `BCH_ADR_CFG) begin
            rd_val = {28'h000_0000, mdc};
        end else if (wb_adr_i == `BCH_ADR_STAT) begin
            rd_val[`BCH_STAT_BUSY]    = busy;
            rd_val[`BCH_STAT_READY]   = ready;
            rd_val[`BCH_STAT_DONE]    = done;
            rd_val[`BCH_STAT_DEV_ERR] = err_i;
            rd_val[`BCH_STAT_SIGN]    = sign_neg;
            rd_val[`BCH_STAT_FMT_ERR] = fmt_err;
            rd_val[11:8]              = point;
            rd_val[15:12]             = int_digits;
            rd_val[19:16]             = point_lsd;
        end else if (wb_adr_i >= `BCH_ADR_DIG_BASE && wb_adr_i <= `BCH_ADR_DIG_LAST
                     && wb_adr_i[1:0] == 2'h0) begin
            rd_val = {28'h000_0000, digs[rd_idx]};
        end
        next_ack = rd_acc;
        next_dat = (rd_acc && !wb_we_i) ? rd_val : 32'h0000_0000;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ======================================================================
    // pin outputs, all registered
    // ======================================================================
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            instr_in_lines_o <= 6'h00;
            hold_o           <= 1'b0;
            por_o            <= 1'b0;
            buf_gate_a_o     <= 1'b0;
            buf_gate_b_o     <= 1'b0;
        end else begin
            instr_in_lines_o <= next_word;
            hold_o           <= next_hold;
            por_o            <= next_por;
            buf_gate_a_o     <= next_gate;
            buf_gate_b_o     <= next_gate;
        end
    end

endmodule : bch_host

// ### design/bch_sync.sv
`timescale 1ns/100ps

// ==========================================================================
// two-stage synchroniser
// ==========================================================================
module bch_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // levels
    bch_sync_if.sink  sig
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] sync_q;
    logic [W-1:0] next_sync;

    // first stage is read only by the second
    always_comb begin
        next_meta = sig.raw;
        next_sync = meta;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= '1;
            sync_q <= '1;
        end else begin
            meta   <= next_meta;
            sync_q <= next_sync;
        end
    end

    assign sig.sync = sync_q;
endmodule : bch_sync

// ### tb/bch_dev_model.sv
`timescale 1ns/100ps

// ==========================================================================
// behavioural unit, a microcycle is UC host clocks
// ==========================================================================
module bch_dev_model #(
    parameter int         UC       = 4,
    parameter logic [5:0] OUT_WORD = 6'h2a // arbitrary output instruction code
) (
    // clock
    input  wire logic        clk_i,
    // from host
    input  wire logic        por_i,
    input  wire logic        hold_i,
    input  wire logic [5:0]  lines_i,
    // from bench
    input  wire logic [3:0]  mdc_i,
    input  wire logic [47:0] xreg_i,
    // to host, and latched word to bench
    output logic             rdy_o,
    output logic             strobe_n_o,
    output logic             phase_o,
    output logic             err_o,
    output logic      [3:0]  dig_o,
    output logic      [5:0]  word_o
);
    int n;

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask : tick

    // one handshake; an output word then streams digits at a fixed pace
    task automatic serve;
        rdy_o <= 1'b1;
        tick(1);
        while (hold_i && !por_i) tick(1);
        if (por_i) return;
        tick(UC);
        rdy_o <= 1'b0;
        word_o <= lines_i;
        tick(UC);
        if (lines_i == OUT_WORD) begin
            phase_o <= 1'b0;
            for (int d = 2; d <= mdc_i + 3; d++) begin
                strobe_n_o <= 1'b0;
                tick(UC);
                strobe_n_o <= 1'b1;
                dig_o <= xreg_i[4*d +: 4];
                tick(13 * UC);
            end
            phase_o <= 1'b1;
            dig_o <= ~dig_o; // stale digit inverted so it differs
            tick(UC);
        end
    endtask : serve

    // power-up and a long clear pulse share one init sequence
    initial begin
        word_o = 6'h00;
        dig_o = 4'h5;
        forever begin
            {rdy_o, phase_o, err_o, strobe_n_o} <= 4'b0001;
            tick(2 * UC);
            repeat (2) begin
                rdy_o <= 1'b1;
                tick(UC);
                rdy_o <= 1'b0;
                tick(UC);
            end
            phase_o <= 1'b1;
            tick(2 * UC);
            do begin
                n = 0;
                while (!por_i) serve();
                while (por_i) begin
                    n++;
                    tick(1);
                end
            end while (n < 8);
        end
    end
endmodule : bch_dev_model

// ### tb/bch_host_chk.sv
`timescale 1ns/100ps

// ==========================================================================
// host port checker
// ==========================================================================
module bch_host_chk #(
    parameter int STRETCH_CYC = 20
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [5:0] instr_in_lines_o,
    input wire logic       hold_o,
    input wire logic       por_o,
    input wire logic       rdy_i,
    input wire logic       digit_strobe_n_i,
    input wire logic       buf_gate_a_o,
    input wire logic       buf_gate_b_o
);
    localparam int POR_CYC = 2500;
    int unsigned por_cnt;
    int unsigned fall_cnt;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // clear pulse length, saturating age of last strobe fall
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_cnt <= 0;
            fall_cnt <= 0;
        end else begin
            por_cnt <= por_o ? por_cnt + 1 : 0;
            fall_cnt <= $fell(digit_strobe_n_i) ? 1 : (fall_cnt < 99999 ? fall_cnt + 1 : fall_cnt);
        end
    end

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_gate;
        buf_gate_a_o || buf_gate_b_o;
    endsequence

    property p_ack_next;   s_req |=> wb_ack_o; endproperty
    property p_ack_once;   wb_ack_o |=> !wb_ack_o; endproperty
    property p_gates;      s_gate |-> buf_gate_a_o && buf_gate_b_o ##1 !buf_gate_a_o; endproperty
    property p_stretch;
        s_gate |-> fall_cnt >= STRETCH_CYC && fall_cnt <= STRETCH_CYC + 8;
    endproperty
    property p_gate_high;
        s_gate |-> $past(digit_strobe_n_i, 1) && $past(digit_strobe_n_i, 3);
    endproperty
    property p_lines;      !hold_o && !por_o |-> $stable(instr_in_lines_o); endproperty
    property p_por_len;    $fell(por_o) |-> por_cnt == POR_CYC; endproperty
    property p_skip;       $fell(por_o) |-> !hold_o [*8]; endproperty
    property p_hold_fall;  $fell(hold_o) |-> por_o || $past(rdy_i, 2); endproperty
    property p_hold_rise;  $rose(hold_o) |-> !$past(rdy_i, 2); endproperty

    a_ack_next:  assert property (p_ack_next) else $error("ack missing after request");
    a_ack_once:  assert property (p_ack_once) else $error("ack longer than one cycle");
    a_gates:     assert property (p_gates) else $error("buffer gates apart or long");
    a_stretch:   assert property (p_stretch) else $error("gate off stretched strobe");
    a_gate_high: assert property (p_gate_high) else $error("gate before strobe high");
    a_lines:     assert property (p_lines) else $error("word moved while sampled");
    a_por_len:   assert property (p_por_len) else $error("clear pulse length wrong");
    a_skip:      assert property (p_skip) else $error("wait raised during skip");
    a_hold_fall: assert property (p_hold_fall) else $error("wait dropped early");
    a_hold_rise: assert property (p_hold_rise) else $error("wait raised early");
endmodule : bch_host_chk

bind bch_host bch_host_chk #(.STRETCH_CYC(STRETCH_CYC)) i_bch_host_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .instr_in_lines_o(instr_in_lines_o), .hold_o(hold_o),
    .por_o(por_o), .rdy_i(rdy_i), .digit_strobe_n_i(digit_strobe_n_i),
    .buf_gate_a_o(buf_gate_a_o), .buf_gate_b_o(buf_gate_b_o)
);

// ### tb/test_bch_host.sv
`timescale 1ns/100ps

// ==========================================================================
// host port testbench
// ==========================================================================
module test_bch_host;
    logic        clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, hold, por;
    logic        rdy, strobe_n, phase, err, ga, gb;
    logic [7:0]  wb_adr;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic [5:0]  lines, word, w;
    logic [3:0]  dig, mdc, m, p;
    logic [47:0] xreg, x;
    int          seed, mismatches, cmp_count;

    bch_host #(.STRETCH_CYC(20)) i_bch_host (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .instr_in_lines_o(lines), .hold_o(hold), .por_o(por),
        .rdy_i(rdy), .digit_strobe_n_i(strobe_n), .instr_phase_select_i(phase),
        .err_i(err), .dig_out_i(dig), .buf_gate_a_o(ga), .buf_gate_b_o(gb)
    );
    bch_dev_model i_bch_dev_model (
        .clk_i(clk_i), .por_i(por), .hold_i(hold), .lines_i(lines), .mdc_i(mdc),
        .xreg_i(xreg), .rdy_o(rdy), .strobe_n_o(strobe_n), .phase_o(phase), .err_o(err),
        .dig_o(dig), .word_o(word)
    );

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // classic single cycle; only the watchdog bounds the wait
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} <= {2'b11, we, a, d};
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_dat_r;
        {wb_cyc, wb_stb} <= 2'b00;
    endtask : bus

    task automatic get(input logic [7:0] a);
        bus(1'b0, a, 32'h0, rd);
    endtask : get

    task automatic poll(input int bitn);
        rd = '0;
        for (int i = 0; i < 2000 && rd[bitn] !== 1'b1; i++) get(8'h08);
        chk("status flag", {31'h0, rd[bitn]}, 32'h1);
    endtask : poll

    task automatic clr_done;
        bus(1'b1, 8'h08, 32'h4, rd);
        get(8'h08);
        chk("done cleared", {31'h0, rd[2]}, 32'h0);
    endtask : clr_done

    // status after output: idle, ready, done, no device error
    function automatic logic [31:0] exp_stat(input logic [47:0] xv, input logic [3:0] mv);
        logic [3:0] pv;
        pv = xv[15:12];
        return {12'h0, 4'hc - mv, 4'hc - pv, pv, 2'b00, (pv < 4'hc - mv || pv > 4'hb), xv[8],
                4'b0110};
    endfunction : exp_stat

    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    // watchdog, far beyond the run of under five thousand cycles
    initial begin
        #(50000 * 8);
        mismatches++;
        summarize();
    end

    initial begin
        seed = 32'h8409048d;
        {mismatches, cmp_count} = '0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
        {mdc, xreg} = {4'h8, 48'h0};
        rst_i = 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        get(8'h04);
        chk("cfg reset", rd, 32'h8);
        bus(1'b1, 8'h00, 32'h100, rd); // refused before init
        get(8'h08);
        chk("status reset", {28'h0, rd[3:0]}, 32'h0);
        bus(1'b1, 8'h30, 32'h3, rd);
        get(8'h30);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        bus(1'b1, 8'h00, 32'h200, rd);
        poll(1);
        chk("hold idle", {31'h0, hold}, 32'h1);
        clr_done();
        for (int v = 0; v < 2; v++) begin
            bus(1'b1, 8'h04, v ? 32'h9 : 32'h0, rd);
            get(8'h04);
            chk("cfg refused", rd, 32'h8);
        end
        $display("test init done");
        w = 6'($unsigned($random(seed)) % 32);
        bus(1'b1, 8'h00, {21'h0, 3'b001, 2'b00, w}, rd);
        poll(2);
        chk("word at device", {26'h0, word}, {26'h0, w});
        get(8'h00);
        chk("word readback", {26'h0, rd[5:0]}, {26'h0, w});
        clr_done();
        $display("test send done");
        // full count, one digit, random count with point out of range
        for (int t = 0; t < 3; t++) begin
            m = (t == 0) ? 4'h8 : (t == 1) ? 4'h1 : 4'(1 + $unsigned($random(seed)) % 8);
            for (int d = 0; d < 12; d++) x[4*d +: 4] = 4'($unsigned($random(seed)) % 10);
            x[11:8] = {3'b000, x[8]};
            p = 4'hc - m + 4'($unsigned($random(seed)) % m);
            x[15:12] = (t == 2) ? 4'hb - m : p;
            bus(1'b1, 8'h04, {28'h0, m}, rd);
            get(8'h04);
            chk("cfg count", rd, {28'h0, m});
            {mdc, xreg} <= {m, x};
            bus(1'b1, 8'h00, {21'h0, 3'b101, 2'b00, 6'h2a}, rd);
            poll(2);
            chk("status fields", rd, exp_stat(x, m));
            for (int d = 2; d <= m + 3; d++) begin
                get(8'(8'h40 + 4 * d));
                chk("digit", rd, {28'h0, x[4*d +: 4]});
            end
            clr_done();
            $display("test receive %0d done", t);
        end
        summarize();
    end
endmodule : test_bch_host
